// file: inc/startup_pkg.sv
// startup_pkg: constants and carriers for the converter start-up sequencer
// assumes a 100 MHz system clock; set contents come from an external store
package startup_pkg;

    localparam int CLK_PERIOD_NS   = 10;
    // power-up to reset pulse, least time
    localparam int POWER_ON_MS     = 1;
    localparam int POWER_ON_CYC    =
        (POWER_ON_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset pulse width, least time
    localparam int RESET_PULSE_US  = 1;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset release to first select, least time
    localparam int SELECT_GAP_NS   = 100;
    localparam int SELECT_GAP_CYC  = (SELECT_GAP_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    // interleaving estimation wait
    localparam int IL_WAIT_MS      = 50;
    localparam int IL_WAIT_CYC     = (IL_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

    // framing code for which this start-up order holds
    localparam logic [19:0] FRAMING_CODE = 20'h1_4384; // 82820 decimal

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // configuration sets, in the order they must be written
    typedef enum logic [2:0]
    {
        SET_ANALOG_TRIM    = 3'b000,
        SET_INTERLEAVE_A   = 3'b001,
        SET_INTERLEAVE_B   = 3'b010,
        SET_NONLINEARITY_A = 3'b011,
        SET_NONLINEARITY_B = 3'b100,
        SET_LINK_AND_DDC   = 3'b101
    } config_set_e;

    // one register write handed to the serial port engine
    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } reg_write_s;

    // request to the external set store: which set, which zone, which entry
    typedef struct packed
    {
        config_set_e set;
        logic [1:0]  zone;
        logic [7:0]  index;
    } set_fetch_s;

endpackage

// file: logic/delay_timer.sv
// delay_timer: loads a cycle count and reports when it has run out
// assumes a single clock; start may be pulsed at any time to reload
`timescale 1ns/1ps
module delay_timer
    import startup_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             start_i,
    input  wire logic [WIDTH-1:0] count_i,
    output logic                  done_o
);

    logic [WIDTH-1:0] left_reg;
    logic [WIDTH-1:0] left_next;
    logic             done_reg;
    logic             done_next;

    always_comb
    begin
        left_next = left_reg;
        done_next = 1'b0;
        if (start_i)
        begin
            left_next = count_i;
        end
        else if (left_reg != '0)
        begin
            left_next = left_reg - 1'b1;
            done_next = (left_reg == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            left_reg <= '0;
            done_reg <= 1'b0;
        end
        else
        begin
            left_reg <= left_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;

endmodule

// file: logic/converter_startup.sv
// converter_startup: host-side power-up sequencer for a dual-channel
// rf-sampling converter. drives the reference enable, the reset pin and a
// stream of register writes to a serial port engine outside this module.
// assumes the serial engine handshakes each write and raises select itself.
//
// How it works
// - sequence targets bypass mode, 12-bit output, framing code 82820
// - reference signal is enabled before the reset pulse is raised
// - reset pin goes low, then high once, then low again
// - reset rises no sooner than 1 ms after power good
// - reset stays high for at least 1 us
// - first serial select comes at least 100 ns after reset falls
// - analog trim set is written first after every power-up
// - channel a interleave set for chosen zone follows
// - channel b interleave set for chosen zone follows channel a
// - wait 50 ms after interleave sets while device estimates errors
// - nonlinearity sets written after the wait, channel a then b
// - link framing and down-converter set is written last
`timescale 1ns/1ps
module converter_startup
    import startup_pkg::*;
#(
    parameter int POWER_ON_CYCLES = POWER_ON_CYC,
    parameter int IL_WAIT_CYCLES  = IL_WAIT_CYC
)
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        start_i,
    input  wire logic [1:0]  zone_i,
    output set_fetch_s       fetch_o,
    input  wire logic        fetch_valid_i,
    input  wire logic        fetch_last_i,
    input  wire reg_write_s  fetch_data_i,
    output reg_write_s       write_o,
    output logic             write_valid_o,
    input  wire logic        write_ready_i,
    output logic             sysref_en_o,
    output logic             converter_reset_o,
    output logic [19:0]      framing_code_o,
    output logic             busy_o,
    output logic             done_o
);

    typedef enum logic [3:0]
    {
        ST_IDLE      = 4'b0000,
        ST_POWER_ON  = 4'b0001,
        ST_RESET_HI  = 4'b0010,
        ST_RESET_GAP = 4'b0011,
        ST_FETCH     = 4'b0100,
        ST_WRITE     = 4'b0101,
        ST_IL_WAIT   = 4'b0110,
        ST_DONE      = 4'b0111
    } state_e;

    state_e      state_reg;
    state_e      state_next;
    config_set_e set_reg;
    config_set_e set_next;
    logic [7:0]  index_reg;
    logic [7:0]  index_next;
    logic [1:0]  zone_reg;
    logic [1:0]  zone_next;
    logic        last_reg;
    logic        last_next;
    reg_write_s  write_reg;
    reg_write_s  write_next;
    logic        wvalid_reg;
    logic        wvalid_next;
    logic        sysref_reg;
    logic        sysref_next;
    logic        rst_pin_reg;
    logic        rst_pin_next;
    logic        done_reg;
    logic        done_next;
    logic        busy_reg;
    logic        busy_next;
    logic        timer_start;
    logic [31:0] timer_count;
    logic        timer_done;

    delay_timer #(
        .WIDTH   (32)
    ) u_timer (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .start_i (timer_start),
        .count_i (timer_count),
        .done_o  (timer_done)
    );

    always_comb
    begin
        state_next   = state_reg;
        set_next     = set_reg;
        index_next   = index_reg;
        zone_next    = zone_reg;
        last_next    = last_reg;
        write_next   = write_reg;
        wvalid_next  = wvalid_reg;
        sysref_next  = sysref_reg;
        rst_pin_next = rst_pin_reg;
        done_next    = done_reg;
        busy_next    = busy_reg;
        timer_start  = 1'b0;
        timer_count  = '0;
        case (state_reg)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    // zone latched so every set of one run matches
                    zone_next   = zone_i;
                    sysref_next = 1'b1;
                    done_next   = 1'b0;
                    busy_next   = 1'b1;
                    timer_start = 1'b1;
                    timer_count = 32'(POWER_ON_CYCLES);
                    state_next  = ST_POWER_ON;
                end
            end
            ST_POWER_ON:
            begin
                if (timer_done)
                begin
                    rst_pin_next = 1'b1;
                    timer_start  = 1'b1;
                    timer_count  = 32'(RESET_PULSE_CYC);
                    state_next   = ST_RESET_HI;
                end
            end
            ST_RESET_HI:
            begin
                if (timer_done)
                begin
                    rst_pin_next = 1'b0;
                    timer_start  = 1'b1;
                    timer_count  = 32'(SELECT_GAP_CYC);
                    state_next   = ST_RESET_GAP;
                end
            end
            ST_RESET_GAP:
            begin
                if (timer_done)
                begin
                    set_next   = SET_ANALOG_TRIM;
                    index_next = '0;
                    state_next = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                if (fetch_valid_i)
                begin
                    write_next  = fetch_data_i;
                    last_next   = fetch_last_i;
                    wvalid_next = 1'b1;
                    state_next  = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                // next entry only after the port has taken this one
                if (write_ready_i)
                begin
                    wvalid_next = 1'b0;
                    index_next  = index_reg + 8'h01;
                    state_next  = ST_FETCH;
                    if (last_reg)
                    begin
                        index_next = '0;
                        case (set_reg)
                            SET_ANALOG_TRIM:
                                set_next = SET_INTERLEAVE_A;
                            SET_INTERLEAVE_A:
                                set_next = SET_INTERLEAVE_B;
                            SET_INTERLEAVE_B:
                            begin
                                timer_start = 1'b1;
                                timer_count = 32'(IL_WAIT_CYCLES);
                                state_next  = ST_IL_WAIT;
                            end
                            SET_NONLINEARITY_A:
                                set_next = SET_NONLINEARITY_B;
                            SET_NONLINEARITY_B:
                                set_next = SET_LINK_AND_DDC;
                            default:
                                state_next = ST_DONE;
                        endcase
                    end
                end
            end
            ST_IL_WAIT:
            begin
                if (timer_done)
                begin
                    set_next   = SET_NONLINEARITY_A;
                    state_next = ST_FETCH;
                end
            end
            ST_DONE:
            begin
                done_next  = 1'b1;
                busy_next  = 1'b0;
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_reg   <= ST_IDLE;
            set_reg     <= SET_ANALOG_TRIM;
            index_reg   <= '0;
            zone_reg    <= '0;
            last_reg    <= 1'b0;
            write_reg   <= '0;
            wvalid_reg  <= 1'b0;
            sysref_reg  <= 1'b0;
            rst_pin_reg <= 1'b0;
            done_reg    <= 1'b0;
            busy_reg    <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            set_reg     <= set_next;
            index_reg   <= index_next;
            zone_reg    <= zone_next;
            last_reg    <= last_next;
            write_reg   <= write_next;
            wvalid_reg  <= wvalid_next;
            sysref_reg  <= sysref_next;
            rst_pin_reg <= rst_pin_next;
            done_reg    <= done_next;
            busy_reg    <= busy_next;
        end
    end

    // fetch request is registered state, so it is flop-driven
    assign fetch_o            = '{set: set_reg, zone: zone_reg,
                                  index: index_reg};
    assign write_o            = write_reg;
    assign write_valid_o      = wvalid_reg;
    assign sysref_en_o        = sysref_reg;
    assign converter_reset_o  = rst_pin_reg;
    assign framing_code_o     = FRAMING_CODE;
    assign busy_o             = busy_reg;
    assign done_o             = done_reg;

endmodule

// file: test/startup_asserts.sv
// startup_asserts: port-level checks on the start-up sequencer
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module startup_asserts
    import startup_pkg::*;
#(
    parameter int POWER_ON_CYCLES = POWER_ON_CYC,
    parameter int IL_WAIT_CYCLES  = IL_WAIT_CYC
)
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        start_i,
    input wire logic [1:0]  zone_i,
    input wire set_fetch_s  fetch_o,
    input wire logic        fetch_valid_i,
    input wire logic        fetch_last_i,
    input wire reg_write_s  fetch_data_i,
    input wire reg_write_s  write_o,
    input wire logic        write_valid_o,
    input wire logic        write_ready_i,
    input wire logic        sysref_en_o,
    input wire logic        converter_reset_o,
    input wire logic [19:0] framing_code_o,
    input wire logic        busy_o,
    input wire logic        done_o
);
    logic [31:0] on_reg;
    logic [31:0] hi_reg;
    logic [31:0] gap_reg;
    logic        seen_reg;
    always_ff @(posedge clk_i)
    begin
        on_reg   <= (reset_i || !sysref_en_o) ? '0 : on_reg + 1;
        hi_reg   <= (reset_i || !converter_reset_o) ? '0 : hi_reg + 1;
        gap_reg  <= (reset_i || (write_valid_o && write_ready_i)) ? '0
                    : gap_reg + 1;
        seen_reg <= !reset_i && busy_o && (seen_reg || converter_reset_o);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // eleven quiet cycles cover the select gap with one cycle of margin
    sequence quiet_s;
        !write_valid_o[*8] ##1 !write_valid_o[*3];
    endsequence
    ref_first_a: assert property ($rose(converter_reset_o) |->
        sysref_en_o && on_reg >= POWER_ON_CYCLES) else $error("early pulse");
    pulse_once_a: assert property ($rose(converter_reset_o) |->
        !seen_reg) else $error("second reset pulse");
    pulse_width_a: assert property ($fell(converter_reset_o) |->
        hi_reg >= RESET_PULSE_CYC) else $error("short reset pulse");
    select_gap_a: assert property ($fell(converter_reset_o) |->
        quiet_s) else $error("write too soon after reset");
    write_hold_a: assert property (write_valid_o && !write_ready_i |=>
        write_valid_o && $stable(write_o)) else $error("write dropped");
    set_order_a: assert property ($changed(fetch_o.set) &&
        fetch_o.set != SET_ANALOG_TRIM |-> fetch_o.set ==
        $past(fetch_o.set) + 3'd1) else $error("set order broken");
    il_wait_a: assert property ($rose(write_valid_o) &&
        fetch_o.set == SET_NONLINEARITY_A && fetch_o.index == 8'h00 |->
        gap_reg >= IL_WAIT_CYCLES) else $error("wait too short");
    done_last_a: assert property ($rose(done_o) |->
        !busy_o && gap_reg <= 3) else $error("late done");
    framing_a: assert property (framing_code_o == 20'h1_4384)
        else $error("wrong framing code");
endmodule

// file: test/converter_model.sv
// converter_model: set store and serial engine facing the sequencer
// assumes fetch requests are read straight off the registered fetch port
`timescale 1ns/1ps
module converter_model
    import startup_pkg::*;
(
    input  wire logic       clk_i,
    input  wire set_fetch_s fetch_i,
    output logic            fetch_valid_o,
    output logic            fetch_last_o,
    output reg_write_s      fetch_data_o,
    output logic            write_ready_o
);
    int         seed;
    reg_write_s entry;
    logic       last;
    // set s holds s+1 entries so the one-entry case is covered
    always_comb
    begin
        entry.addr   = {fetch_i.set, fetch_i.zone, 3'b000, fetch_i.index};
        entry.data   = fetch_i.index ^ {fetch_i.set, fetch_i.zone, 3'b101};
        last         = fetch_i.index == {5'b0_0000, fetch_i.set};
        // when idle, show the inverse so stale data cannot pass
        fetch_data_o = fetch_valid_o ? entry : ~entry;
        fetch_last_o = fetch_valid_o ? last : !last;
    end
    initial
    begin
        seed = 59;
        fetch_valid_o = 1'b0;
        write_ready_o = 1'b0;
    end
    always @(negedge clk_i)
    begin
        fetch_valid_o <= ($random(seed) % 3) != 0;
        write_ready_o <= ($random(seed) % 2) == 0;
    end
endmodule

// file: test/tb_top.sv
// tb_top: drives start and zone, checks every write and the pulse timing
// assumes shortened power-on and interleave wait counts
`timescale 1ns/1ps
module tb_top;
    import startup_pkg::*;
    localparam int PON = 20;
    localparam int ILW = 50;
    logic        clk_i, reset_i, start_i;
    logic        fetch_valid_i, fetch_last_i, write_valid_o, write_ready_i;
    logic        sysref_en_o, converter_reset_o, busy_o, done_o;
    logic [1:0]  zone_i;
    logic [19:0] framing_code_o;
    set_fetch_s  fetch_o;
    reg_write_s  fetch_data_i;
    reg_write_s  write_o;
    reg_write_s  exp_q[$];
    reg_write_s  exp_w;
    int          n_errors, n_checks, seed, cyc, t0, t_il;
    converter_startup #(.POWER_ON_CYCLES(PON), .IL_WAIT_CYCLES(ILW)) dut_u
        (.clk_i, .reset_i, .start_i, .zone_i, .fetch_o, .fetch_valid_i,
         .fetch_last_i, .fetch_data_i, .write_o, .write_valid_o,
         .write_ready_i, .sysref_en_o, .converter_reset_o, .framing_code_o,
         .busy_o, .done_o);
    converter_model far_u (.clk_i, .fetch_i(fetch_o),
        .fetch_valid_o(fetch_valid_i), .fetch_last_o(fetch_last_i),
        .fetch_data_o(fetch_data_i), .write_ready_o(write_ready_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic run(input logic [1:0] z, input bit cut);
        reg_write_s w;
        exp_q.delete();
        for (int s = 0; s < 6; s++)
            for (int i = 0; i <= s; i++)
            begin
                w.addr = {s[2:0], z, 3'b000, i[7:0]};
                w.data = i[7:0] ^ {s[2:0], z, 3'b101};
                exp_q.push_back(w);
            end
        repeat ($unsigned($random(seed)) % 4) @(negedge clk_i);
        start_i = 1'b1;
        zone_i  = z;
        @(negedge clk_i);
        start_i = 1'b0;
        t0 = cyc;
        check({sysref_en_o, busy_o}, 2'b11);
        while (!converter_reset_o) @(negedge clk_i);
        // the sequencer acts on timer done one edge after it rises, so the pulse rises one cycle late
        check(cyc - t0 == PON + 1, 1);
        check(sysref_en_o, 1);
        if (cut)
        begin
            reset_i = 1'b1;
            repeat (3) @(negedge clk_i);
            check({sysref_en_o, converter_reset_o, busy_o, write_valid_o}, 0);
            reset_i = 1'b0;
            return;
        end
        t0 = cyc;
        start_i = 1'b1; // refused while busy
        while (converter_reset_o) @(negedge clk_i);
        start_i = 1'b0;
        check(cyc - t0 >= RESET_PULSE_CYC, 1);
        t0 = cyc;
        while (!write_valid_o) @(negedge clk_i);
        check(cyc - t0 > SELECT_GAP_CYC, 1);
        while (!done_o) @(negedge clk_i);
        check({busy_o, done_o, framing_code_o}, {2'b01, 20'h1_4384});
        check(exp_q.size(), 0);
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // accepted writes are compared in order against the expected stream
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (!reset_i && write_valid_o && write_ready_i)
        begin
            exp_w = exp_q.size() ? exp_q.pop_front() : '1;
            check(write_o, exp_w);
            if (write_o.addr[15:13] == 3'd2 && write_o.addr[7:0] == 8'd2)
                t_il = cyc;
            if (write_o.addr[15:13] == 3'd3 && write_o.addr[7:0] == 8'd0)
                check(cyc - t_il >= ILW, 1);
        end
        if (cyc == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end
    initial
    begin
        seed = 59;
        cyc = 0;
        n_errors = 0;
        n_checks = 0;
        reset_i = 1'b1;
        start_i = 1'b0;
        zone_i = 2'b00;
        repeat (3) @(negedge clk_i);
        reset_i = 1'b0;
        run(2'd1, 1'b1);
        for (int z = 0; z < 4; z++)
            run(z[1:0], 1'b0);
        end_of_test();
    end
endmodule
bind converter_startup startup_asserts #(.POWER_ON_CYCLES(POWER_ON_CYCLES),
    .IL_WAIT_CYCLES(IL_WAIT_CYCLES)) chk_u (.clk_i, .reset_i, .start_i,
    .zone_i, .fetch_o, .fetch_valid_i, .fetch_last_i, .fetch_data_i,
    .write_o, .write_valid_o, .write_ready_i, .sysref_en_o,
    .converter_reset_o, .framing_code_o, .busy_o, .done_o);
